// ---- rtl/wdom_top.sv ----
// How it works
// - 15-bit counter, prescale six or 192
// - software sets only upper seven bits
// - start by software bit or pin
// - running watchdog cannot be stopped
// - overflow of running watchdog resets chip
// - refresh loads reload into upper bits
// - readable flag shows watchdog reset cause
// - counter holds in idle, power-down
// - timeout spans about 38us to 157ms
// - slow main osc: rc clock, reset
// - recovery adds about 1 ms reset
// - rc clock supplied from power-on
// - power-down wake waits about 1 ms
//
// Implementation choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
module wdom_top #(
	parameter int SETTLE_CYC = wdom_pkg::SETTLE_CYCLES
) (
	// clock and external reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input wire logic [2:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// processor mode and pins
	input wire logic HW_WATCHDOG_START_PIN,
	input wire logic IDLE_MODE,
	input wire logic POWER_DOWN,
	input wire logic WAKEUP,
	// oscillator samples
	input wire logic MAIN_OSC_TICK,
	input wire logic RC_OSC_TICK,
	// reset and clock control
	output logic WD_RESET,
	output logic OSC_RESET,
	output logic CPU_HOLD,
	output logic CLK_SEL_RC
);
	localparam int SW = $clog2(SETTLE_CYC + 1);

	// refuse settle counts the logic cannot serve
	if (SETTLE_CYC < 1) begin : g_chk
		$error("settle count must be at least one");
	end

	wdom_pkg::wdom_bus_type bus; // current access
	logic [14:0] cnt_ff; // watchdog counter
	logic [7:0] presc_ff; // prescale divider
	logic [6:0] reload_ff; // reload for upper bits
	logic rate_ff; // high selects slow prescale
	logic running_ff; // watchdog started
	logic armed_ff; // refresh bit seen last write
	logic cause_ff; // last reset came from watchdog
	logic wd_reset_ff; // overflow reset pulse
	logic [7:0] rdata_ff; // read answer
	wdom_pkg::wdom_state_type state_ff, nxt_state;
	logic [SW-1:0] settle_ff; // settle delay count
	logic [4:0] rcwin_ff; // rc ticks in window
	logic [7:0] mcnt_ff; // main ticks in window
	logic win_end; // comparison window closes
	logic main_fast; // main beat rc in window
	logic settle_done; // settle delay over
	logic halted; // idle or power-down
	logic tick; // counter advance strobe
	logic st_wr; // start bit written
	logic rf_wr; // refresh bit written
	logic do_refresh; // adjacent pair completed
	logic overflow; // counter wraps

	// gather the bus signals
	assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	// decode a written bit of the control register
	function automatic logic ctrl_bit(input wdom_pkg::wdom_bus_type b,
		input int pos);
		return b.wr && b.addr == wdom_pkg::ADDR_CTRL && b.wdata[pos];
	endfunction

	assign st_wr = ctrl_bit(bus, wdom_pkg::BIT_START);
	assign rf_wr = ctrl_bit(bus, wdom_pkg::BIT_REFRESH);
	assign halted = IDLE_MODE || POWER_DOWN;
	// prescale wraps at 6 or 192 oscillator cycles
	assign tick = (presc_ff == (rate_ff ? 8'(wdom_pkg::DIV_SLOW - 1) :
		8'(wdom_pkg::DIV_FAST - 1)));
	assign overflow = running_ff && !halted && tick &&
		cnt_ff == wdom_pkg::CNT_TOP;
	// start write counts as refresh only right after refresh write
	assign do_refresh = armed_ff && st_wr && !rf_wr;

	// prescale divider, frozen while halted
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !running_ff || overflow) begin
			presc_ff <= 8'h00;
		end else if (halted) begin
			presc_ff <= presc_ff;
		end else if (tick) begin
			presc_ff <= 8'h00;
		end else begin
			presc_ff <= presc_ff + 8'h01;
		end
	end

	// software settings
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			reload_ff <= wdom_pkg::RELOAD_RST;
			rate_ff <= 1'b0;
		end else if (bus.wr && bus.addr == wdom_pkg::ADDR_RELOAD) begin
			reload_ff <= bus.wdata[6:0];
		end else if (bus.wr && bus.addr == wdom_pkg::ADDR_CTRL) begin
			rate_ff <= bus.wdata[wdom_pkg::BIT_RATE];
		end
	end

	// refresh arming: any other write disarms
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || overflow) begin
			armed_ff <= 1'b0;
		end else if (bus.wr) begin
			armed_ff <= rf_wr && !st_wr;
		end
	end

	// run state: only an overflow reset stops it
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || overflow) begin
			running_ff <= 1'b0;
		end else if (st_wr || HW_WATCHDOG_START_PIN) begin
			running_ff <= 1'b1;
		end else begin
			running_ff <= running_ff;
		end
	end

	// watchdog counter
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || overflow) begin
			cnt_ff <= wdom_pkg::CNT_RST;
		end else if (running_ff && do_refresh) begin
			// lower bits clear, upper take the reload
			cnt_ff <= {reload_ff, 8'h00};
		end else if (running_ff && !halted && tick) begin
			cnt_ff <= cnt_ff + 15'h0001;
		end
	end

	// overflow reset pulse and cause flag
	// the flag survives its own reset, only RST_N clears it
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			wd_reset_ff <= 1'b0;
			cause_ff <= 1'b0;
		end else begin
			wd_reset_ff <= overflow;
			cause_ff <= cause_ff || overflow;
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || !bus.rd) begin
			rdata_ff <= 8'h00;
		end else begin
			case (bus.addr)
				wdom_pkg::ADDR_CTRL: begin
					rdata_ff <= 8'(rate_ff) << wdom_pkg::BIT_RATE;
				end
				wdom_pkg::ADDR_RELOAD: begin
					rdata_ff <= {1'b0, reload_ff};
				end
				wdom_pkg::ADDR_STATUS: begin
					rdata_ff <= (8'(cause_ff) << wdom_pkg::BIT_WD_CAUSE) |
						(8'(OSC_RESET) << wdom_pkg::BIT_OSC_FAIL) |
						(8'(running_ff) << wdom_pkg::BIT_RUNNING) |
						(8'(CPU_HOLD) << wdom_pkg::BIT_HOLD);
				end
				wdom_pkg::ADDR_CNT_LO: begin
					rdata_ff <= cnt_ff[7:0];
				end
				wdom_pkg::ADDR_CNT_HI: begin
					rdata_ff <= {1'b0, cnt_ff[14:8]};
				end
				default: begin
					rdata_ff <= 8'h00; // unmapped reads zero
				end
			endcase
		end
	end

	// frequency comparison window counted in rc ticks
	// a stopped main oscillator leaves mcnt at zero, so it fails
	assign win_end = RC_OSC_TICK &&
		rcwin_ff == 5'(wdom_pkg::CMP_WINDOW - 1);
	assign main_fast = mcnt_ff > 8'(wdom_pkg::CMP_WINDOW);
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || win_end || state_ff == wdom_pkg::ST_SLEEP) begin
			rcwin_ff <= 5'h00;
			mcnt_ff <= 8'h00;
		end else begin
			rcwin_ff <= rcwin_ff + 5'(RC_OSC_TICK);
			if (MAIN_OSC_TICK && mcnt_ff != 8'hff) begin
				mcnt_ff <= mcnt_ff + 8'h01;
			end
		end
	end

	// settle delay for the final reset or wake phase
	assign settle_done = settle_ff == SW'(SETTLE_CYC - 1);
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N || (state_ff != wdom_pkg::ST_SETTLE &&
			state_ff != wdom_pkg::ST_WAKE_SETTLE)) begin
			settle_ff <= '0;
		end else if (!settle_done) begin
			settle_ff <= settle_ff + SW'(1);
		end
	end

	// supervisor next state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			wdom_pkg::ST_FAIL: begin
				if (win_end && main_fast) begin
					nxt_state = wdom_pkg::ST_SETTLE;
				end
			end
			wdom_pkg::ST_SETTLE: begin
				if (win_end && !main_fast) begin
					nxt_state = wdom_pkg::ST_FAIL;
				end else if (settle_done) begin
					nxt_state = wdom_pkg::ST_RUN;
				end
			end
			wdom_pkg::ST_RUN: begin
				if (POWER_DOWN) begin
					nxt_state = wdom_pkg::ST_SLEEP;
				end else if (win_end && !main_fast) begin
					nxt_state = wdom_pkg::ST_FAIL;
				end
			end
			wdom_pkg::ST_SLEEP: begin
				if (WAKEUP) begin
					nxt_state = wdom_pkg::ST_WAKE;
				end
			end
			wdom_pkg::ST_WAKE: begin
				if (win_end && main_fast) begin
					nxt_state = wdom_pkg::ST_WAKE_SETTLE;
				end
			end
			wdom_pkg::ST_WAKE_SETTLE: begin
				if (win_end && !main_fast) begin
					nxt_state = wdom_pkg::ST_WAKE;
				end else if (settle_done) begin
					nxt_state = wdom_pkg::ST_RUN;
				end
			end
			default: begin
				nxt_state = wdom_pkg::ST_FAIL;
			end
		endcase
	end

	// supervisor state and registered outputs
	// power-on starts failed, on the rc clock, in reset
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			state_ff <= wdom_pkg::ST_FAIL;
			OSC_RESET <= 1'b1;
			CLK_SEL_RC <= 1'b1;
			CPU_HOLD <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			OSC_RESET <= nxt_state == wdom_pkg::ST_FAIL ||
				nxt_state == wdom_pkg::ST_SETTLE;
			CLK_SEL_RC <= nxt_state == wdom_pkg::ST_FAIL ||
				nxt_state == wdom_pkg::ST_WAKE;
			CPU_HOLD <= nxt_state != wdom_pkg::ST_RUN;
		end
	end

	assign WD_RESET = wd_reset_ff;
	assign RDATA = rdata_ff;

	// reload lands in the upper bits after a proper pair
	refresh_load_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		do_refresh && running_ff && !overflow |=>
		cnt_ff == {$past(reload_ff), 8'h00})
		else $error("refresh did not load reload value");
	// a lone start write leaves the count undisturbed
	lone_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		running_ff && st_wr && !armed_ff && !overflow |=>
		cnt_ff == $past(cnt_ff) || cnt_ff == $past(cnt_ff) + 15'h0001)
		else $error("unpaired start write disturbed counter");
	// halted counter keeps its value
	halt_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		running_ff && halted && !do_refresh |=> $stable(cnt_ff))
		else $error("counter moved while halted");
	// overflow gives reset pulse and cause flag in the same next cycle
	overflow_rst_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		overflow |=> WD_RESET && cause_ff && !running_ff)
		else $error("overflow did not reset");
	// cause flag never drops without external reset
	cause_keep_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		cause_ff |=> cause_ff)
		else $error("watchdog cause flag lost");
	// only overflow stops a running watchdog
	run_stays_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		running_ff && !overflow |=> running_ff)
		else $error("running watchdog stopped");
	// start pin starts the watchdog
	pin_start_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		HW_WATCHDOG_START_PIN && !overflow |=> running_ff)
		else $error("start pin ignored");
	// slow ratio does not advance as the prescale leaves zero
	presc_rate_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		running_ff && !halted && !bus.wr && rate_ff &&
		presc_ff == 8'h00 |=> presc_ff == 8'h01 ##0 $stable(cnt_ff))
		else $error("slow prescale advanced early");
	// failing oscillator runs on rc clock in reset
	fail_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		state_ff == wdom_pkg::ST_FAIL |-> OSC_RESET && CLK_SEL_RC)
		else $error("fail state not held in reset");
	// settle phase keeps reset on main clock
	settle_rst_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		state_ff == wdom_pkg::ST_SETTLE |-> OSC_RESET && !CLK_SEL_RC)
		else $error("settle phase released reset");
	// wake settle holds cpu without reset
	wake_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
		state_ff == wdom_pkg::ST_WAKE_SETTLE |-> CPU_HOLD && !OSC_RESET)
		else $error("wake settle not holding cpu");
endmodule // wdom_top
`default_nettype wire

// ---- rtl/wdom_pkg.sv ----
package wdom_pkg;
	// register indices on the plain byte port
	localparam logic [2:0] ADDR_CTRL = 3'h0;
	localparam logic [2:0] ADDR_RELOAD = 3'h1;
	localparam logic [2:0] ADDR_STATUS = 3'h2;
	localparam logic [2:0] ADDR_CNT_LO = 3'h3;
	localparam logic [2:0] ADDR_CNT_HI = 3'h4;
	// control register fields
	localparam int BIT_REFRESH = 0;
	localparam int BIT_START = 1;
	localparam int BIT_RATE = 2;
	// status register fields
	localparam int BIT_WD_CAUSE = 0;
	localparam int BIT_OSC_FAIL = 1;
	localparam int BIT_RUNNING = 2;
	localparam int BIT_HOLD = 3;
	// reset values
	localparam logic [6:0] RELOAD_RST = 7'h00;
	localparam logic [14:0] CNT_RST = 15'h0000;
	localparam logic [14:0] CNT_TOP = 15'h7fff;
	// prescale ratios of the oscillator clock
	localparam int DIV_FAST = 6;
	localparam int DIV_SLOW = 192;
	// clock and settle time
	localparam int CLK_MHZ = 40;
	localparam int SETTLE_TIME_US = 1000;
	localparam int SETTLE_CYCLES = SETTLE_TIME_US * CLK_MHZ;
	// rc ticks per frequency comparison window
	localparam int CMP_WINDOW = 16;
	// oscillator supervisor states
	typedef enum logic [2:0] {
		ST_FAIL = 3'b000,
		ST_SETTLE = 3'b001,
		ST_RUN = 3'b010,
		ST_SLEEP = 3'b011,
		ST_WAKE = 3'b100,
		ST_WAKE_SETTLE = 3'b101
	} wdom_state_type;
	// one bus access
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} wdom_bus_type;
endpackage

// ---- bench/wdom_top_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module wdom_top_tb;
	// clock, reset and register port
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	// mode pins and oscillator samples
	logic hw_pin = 1'b0;
	logic idle_mode = 1'b0;
	logic power_down = 1'b0;
	logic wakeup = 1'b0;
	logic main_tick = 1'b0;
	logic rc_tick = 1'b0;
	logic main_en = 1'b0; // main oscillator running
	logic [1:0] rc_div = 2'h0; // rc tick every fourth cycle
	// outputs and bookkeeping
	logic wd_reset, osc_reset, cpu_hold, clk_sel_rc;
	int mismatches = 0;
	int num_checks = 0;
	int cyc = 0;
	localparam int SETTLE = 20; // short settle keeps the run brief

	always #12.5 clk_sys = ~clk_sys;

	wdom_top #(.SETTLE_CYC(SETTLE)) wdom_top_i (
		.CLK_SYS(clk_sys), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .HW_WATCHDOG_START_PIN(hw_pin),
		.IDLE_MODE(idle_mode), .POWER_DOWN(power_down), .WAKEUP(wakeup),
		.MAIN_OSC_TICK(main_tick), .RC_OSC_TICK(rc_tick),
		.WD_RESET(wd_reset), .OSC_RESET(osc_reset), .CPU_HOLD(cpu_hold),
		.CLK_SEL_RC(clk_sel_rc)
	);

	// main ticks four times as often as rc, so a window reads as fast
	always @(posedge clk_sys) begin
		rc_div <= rc_div + 2'h1;
		rc_tick <= (rc_div == 2'h3);
		main_tick <= main_en;
	end

	// timeout guard: a hang must still end in the report
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// one-cycle write strobe
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys);
		wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic bus_rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	initial begin
		logic [7:0] d;
		logic [7:0] d2;
		int n;
		cycles(16);
		rst_n <= 1'b0;
		@(posedge clk_sys);
		rst_n <= 1'b1;
		bus_rd(wdom_pkg::ADDR_STATUS, d);
		chk(d, 8'h0a);
		chk({7'h00, clk_sel_rc}, 8'h01);
		// oscillator recovery: settle phase keeps reset asserted
		main_en <= 1'b1;
		for (n = 0; n < 300 && clk_sel_rc !== 1'b0; n++) cycles(1);
		#1 chk({7'h00, osc_reset}, 8'h01);
		for (n = 0; n < 100 && osc_reset !== 1'b0; n++) cycles(1);
		chk({7'h00, n >= SETTLE - 2 && n <= SETTLE + 2}, 8'h01);
		#1 chk({7'h00, cpu_hold}, 8'h00);
		// start, then a stop attempt that must be ignored
		bus_wr(wdom_pkg::ADDR_RELOAD, 8'h7f);
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h02);
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h00);
		bus_rd(wdom_pkg::ADDR_STATUS, d);
		chk(d & 8'h04, 8'h04);
		// refresh broken by another write is discarded
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h01);
		bus_wr(wdom_pkg::ADDR_RELOAD, 8'h7f);
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h02);
		bus_rd(wdom_pkg::ADDR_CNT_HI, d);
		chk(d, 8'h00);
		// idle freezes the count
		idle_mode <= 1'b1;
		bus_rd(wdom_pkg::ADDR_CNT_LO, d);
		cycles(50);
		bus_rd(wdom_pkg::ADDR_CNT_LO, d2);
		chk(d2, d);
		idle_mode <= 1'b0;
		// proper refresh loads upper bits, then overflow resets
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h01);
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h02);
		bus_rd(wdom_pkg::ADDR_CNT_HI, d);
		chk(d, 8'h7f);
		for (n = 0; n < 1700 && wd_reset !== 1'b1; n++) cycles(1);
		chk({7'h00, n >= 1520 && n <= 1540}, 8'h01);
		bus_rd(wdom_pkg::ADDR_STATUS, d);
		chk(d & 8'h05, 8'h01);
		// slow prescale, started from the pin
		bus_wr(wdom_pkg::ADDR_CTRL, 8'h04);
		bus_rd(wdom_pkg::ADDR_CTRL, d);
		chk(d & 8'h04, 8'h04);
		hw_pin <= 1'b1;
		cycles(600);
		bus_rd(wdom_pkg::ADDR_CNT_LO, d);
		chk(d, 8'h03);
		bus_rd(wdom_pkg::ADDR_STATUS, d);
		chk(d & 8'h04, 8'h04);
		// power-down and wake: rc clock, then a settle before run
		power_down <= 1'b1;
		cycles(5);
		chk({7'h00, cpu_hold}, 8'h01);
		power_down <= 1'b0;
		wakeup <= 1'b1;
		cycles(1);
		wakeup <= 1'b0;
		cycles(3);
		chk({7'h00, clk_sel_rc}, 8'h01);
		for (n = 0; n < 300 && clk_sel_rc !== 1'b0; n++) cycles(1);
		#1 chk({7'h00, cpu_hold}, 8'h01);
		for (n = 0; n < 100 && cpu_hold !== 1'b0; n++) cycles(1);
		chk({7'h00, n >= SETTLE - 2 && n <= SETTLE + 2}, 8'h01);
		// unmapped index reads zero
		bus_rd(3'h7, d);
		chk(d, 8'h00);
		// main oscillator fails: rc clock and reset
		main_en <= 1'b0;
		for (n = 0; n < 300 && osc_reset !== 1'b1; n++) cycles(1);
		#1 chk({6'h00, osc_reset, clk_sel_rc}, 8'h03);
		final_report();
	end
endmodule // wdom_top_tb
`default_nettype wire
